// *** tb/irqps_pins.sv ***
`timescale 1ns/100ps
module irqps_pins (
   input wire logic pclk,
   input wire logic [10:0] pat,
   output logic [3:0] port2_line,
   output logic [6:0] port6_line
);
   // Pins held steady across reselects
   always_ff @(posedge pclk) begin
      {port6_line, port2_line} <= pat;
   end
endmodule

// *** tb/irqps_top_bench.sv ***
`timescale 1ns/100ps
module irqps_top_bench;
   logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, err;
   logic [3:0] pstrb = 4'hF;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr;
   logic [10:0] pat = 0;
   logic [3:0] port2_line, port2_buffered;
   logic [6:0] port6_line, port6_buffered, ext_request, e;
   int n_errors = 0, n_tests = 0, cyc = 0;
   always #12.5 pclk = ~pclk;
   irqps_pins u_pins (.pclk, .pat, .port2_line, .port6_line);
   irqps_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .port2_line, .port6_line,
      .ext_request, .port2_buffered, .port6_buffered);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [31:0] x, logic [31:0] s);
      n_tests++;
      if (s !== x) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic xfer(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s = 4'hF);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task final_report;
      $display("Tests %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_regs;
      pat <= 11'h7FF;
      repeat (2) @(posedge pclk);
      xfer(0, 12'h000, 0);
      chk("sel reset", 0, rd);
      xfer(0, 12'h004, 0);
      chk("ibe reset", 0, rd);
      xfer(1, 12'h000, 32'hFF);
      xfer(0, 12'h000, 0);
      chk("sel bit7", 32'h7F, rd);
      xfer(1, 12'h000, 32'h01, 4'hE);
      xfer(0, 12'h000, 0);
      chk("sel strobe gate", 32'h7F, rd);
      xfer(1, 12'h004, 32'h7FF, 4'h1);
      xfer(0, 12'h004, 0);
      chk("ibe low strobe", 32'hFF, rd);
      xfer(1, 12'h004, 0);
      xfer(0, 12'h00C, 0);
      chk("unmapped err", 1, err);
      chk("unmapped data", 0, rd);
      xfer(1, 12'h00C, 32'hFFFFFFFF);
      chk("unmapped wr err", 1, err);
      xfer(0, 12'h000, 0);
      chk("unmapped wr ignored", 32'h7F, rd);
      $display("test regs done");
   endtask
   task t_route;
      logic [7:0] sels [3] = '{8'h00, 8'h7F, 8'h55};
      logic [10:0] pats [2] = '{11'h00F, 11'h7F0};
      foreach (sels[k]) begin
         pat <= 11'h7FF;
         repeat (2) @(posedge pclk);
         xfer(1, 12'h004, 0);
         xfer(1, 12'h000, sels[k]);
         xfer(1, 12'h004, 32'h7FF);
         foreach (pats[j]) begin
            pat <= pats[j];
            repeat (3) @(posedge pclk);
            for (int i = 0; i < 7; i++) begin
               e[i] = sels[k][i] ? pats[j][4+i] : (i < 4 && pats[j][i]);
            end
            chk("request", e, ext_request);
            chk("shared", pats[j], {port6_buffered, port2_buffered});
            xfer(0, 12'h008, 0);
            chk("status", e, rd);
         end
      end
      pat <= 11'h7FF;
      repeat (2) @(posedge pclk);
      xfer(1, 12'h004, 0);
      repeat (3) @(posedge pclk);
      chk("gated", 0, {ext_request, port6_buffered, port2_buffered});
      $display("test route done");
   endtask
   task t_edge;
      xfer(1, 12'h004, 32'h011);
      xfer(1, 12'h000, 0);
      pat <= 11'h010;
      repeat (3) @(posedge pclk);
      chk("a side", 0, ext_request[0]);
      xfer(1, 12'h000, 1);
      repeat (2) @(posedge pclk);
      chk("reselect edge", 1, ext_request[0]);
      pat <= 11'h001;
      repeat (3) @(posedge pclk);
      chk("unselected pin", 0, ext_request[0]);
      pat <= 11'h7FF;
      repeat (2) @(posedge pclk);
      xfer(1, 12'h004, 0);
      $display("test edge done");
   endtask
   task t_reset;
      xfer(1, 12'h004, 32'h7FF);
      xfer(1, 12'h000, 32'h0F);
      repeat (2) @(posedge pclk);
      chk("req before reset", 32'h0F, ext_request);
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      chk("req in reset", 0, ext_request);
      xfer(0, 12'h000, 0);
      chk("sel after reset", 0, rd);
      xfer(0, 12'h004, 0);
      chk("ibe after reset", 0, rd);
      $display("test reset done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         final_report;
      end
   end
   initial begin
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      t_regs;
      t_route;
      t_edge;
      t_reset;
      final_report;
   end
endmodule

// *** verilog/irqps_params.svh ***
`ifndef IRQPS_PARAMS_SVH
`define IRQPS_PARAMS_SVH

// Register byte offsets
`define IRQPS_SEL_OFFSET 12'h000
`define IRQPS_IBE_OFFSET 12'h004
`define IRQPS_STAT_OFFSET 12'h008

// Field positions and widths
`define IRQPS_SEL_RSVD_BIT 7
`define IRQPS_SEL_LOW_N 4
`define IRQPS_SEL_HIGH_N 3
`define IRQPS_IBE_W 11

// Reset values
`define IRQPS_SEL_RESET 8'h00
`define IRQPS_IBE_RESET 11'h000

`endif

// *** verilog/irqps_pkg.sv ***
package irqps_pkg;
   typedef struct packed {
      logic [7:0] sel;
      logic [10:0] ibe;
      logic [6:0] req;
      logic [31:0] rdata;
   } irqps_state_t;
endpackage

// *** verilog/irqps_top.sv ***
`timescale 1ns/100ps
`include "irqps_params.svh"
// Contract
// - Bits 0-3 pick port2 or port6 line
// - Bits 4-6 enable port6 lines 4-6
// - Bit 7 reserved, reads zero, write zero
// - Select register resets to all zero
// - Enabled pin level reaches all its users
// - Output pins need input buffer disabled
// - Select change may produce internal edge
module irqps_top
   import irqps_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] port2_line,
   input wire logic [6:0] port6_line,
   output logic [6:0] ext_request,
   output logic [3:0] port2_buffered,
   output logic [6:0] port6_buffered
);

   generate
      if (ADDR_W < 4) begin : g_bad_addr_w
         $error("ADDR_W too small for the register map");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // State
   irqps_state_t st_r;
   irqps_state_t st_nxt;
   logic [3:0] p2_buf;
   logic [6:0] p6_buf;
   logic [6:0] req_comb;
   logic wr_en;
   logic rd_en;
   logic hit;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign hit = (paddr == `IRQPS_SEL_OFFSET) || (paddr == `IRQPS_IBE_OFFSET)
      || (paddr == `IRQPS_STAT_OFFSET);

   // Input buffers, gated per pin; one level feeds every user
   assign p2_buf = port2_line & st_r.ibe[3:0];
   assign p6_buf = port6_line & st_r.ibe[10:4];

   ////////////////////////////////////////////////////////////////////////////
   // Source selection
   genvar g;
   generate
      for (g = 0; g < `IRQPS_SEL_LOW_N; g++) begin : g_low
         // Pick A or B side pin
         assign req_comb[g] = st_r.sel[g] ? p6_buf[g] : p2_buf[g];
      end
      for (g = `IRQPS_SEL_LOW_N; g < 7; g++) begin : g_high
         // Port6 only when selected
         assign req_comb[g] = st_r.sel[g] & p6_buf[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.req = req_comb;
      if (wr_en && paddr == `IRQPS_SEL_OFFSET) begin
         if (pstrb[0]) begin
            st_nxt.sel = pwdata[7:0];
            st_nxt.sel[`IRQPS_SEL_RSVD_BIT] = 1'b0;
         end
      end else if (wr_en && paddr == `IRQPS_IBE_OFFSET) begin
         if (pstrb[0]) begin
            st_nxt.ibe[7:0] = pwdata[7:0];
         end
         if (pstrb[1]) begin
            st_nxt.ibe[10:8] = pwdata[10:8];
         end
      end
      if (rd_en) begin
         if (paddr == `IRQPS_SEL_OFFSET) begin
            st_nxt.rdata = {24'h000000, st_r.sel};
         end else if (paddr == `IRQPS_IBE_OFFSET) begin
            st_nxt.rdata = {21'h000000, st_r.ibe};
         end else if (paddr == `IRQPS_STAT_OFFSET) begin
            st_nxt.rdata = {25'h0000000, st_r.req};
         end else begin
            st_nxt.rdata = 32'h00000000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.sel <= `IRQPS_SEL_RESET;
         st_r.ibe <= `IRQPS_IBE_RESET;
         st_r.req <= 7'h00;
         st_r.rdata <= 32'h00000000;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata = st_r.rdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign ext_request = st_r.req;
   assign port2_buffered = p2_buf;
   assign port6_buffered = p6_buf;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_low_route: assert property (@(posedge pclk) disable iff (!presetn)
      ext_request[0] == ($past(st_r.sel[0]) ? $past(port6_line[0] & st_r.ibe[4])
      : $past(port2_line[0] & st_r.ibe[0])))
      else $error("request 8 source wrong");
   chk_high_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(st_r.sel[6]) |-> !ext_request[6])
      else $error("request 14 active while unselected");
   chk_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
      st_r.sel[7] == 1'b0)
      else $error("reserved select bit set");
   chk_reset_sel: assert property (@(posedge pclk)
      $rose(presetn) |-> st_r.sel == 8'h00)
      else $error("select not zero after reset");
   chk_buf_share: assert property (@(posedge pclk) disable iff (!presetn)
      port6_buffered[1] == (port6_line[1] & st_r.ibe[5]))
      else $error("buffered level wrong");
   chk_buf_off: assert property (@(posedge pclk) disable iff (!presetn)
      !st_r.ibe[2] |-> !port2_buffered[2])
      else $error("disabled buffer passes level");
   chk_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `IRQPS_SEL_OFFSET && pstrb[0])
      |=> st_r.sel[6:0] == $past(pwdata[6:0]))
      else $error("select write lost");
   chk_unsel_pin: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(!st_r.sel[3]) && $past(port2_line[3] == 1'b0)) |-> !ext_request[3])
      else $error("unselected pin reached request");

   // Every request line against its selected pin
   generate
      for (g = 0; g < `IRQPS_SEL_LOW_N; g++) begin : g_low_chk
         chk_low_each: assert property (@(posedge pclk) disable iff (!presetn)
            ext_request[g] == $past(st_r.sel[g] ? (port6_line[g] & st_r.ibe[4+g])
            : (port2_line[g] & st_r.ibe[g])))
            else $error("low request source wrong");
      end
      for (g = `IRQPS_SEL_LOW_N; g < 7; g++) begin : g_high_chk
         chk_high_each: assert property (@(posedge pclk) disable iff (!presetn)
            ext_request[g] == $past(st_r.sel[g] & port6_line[g] & st_r.ibe[4+g]))
            else $error("high request source wrong");
      end
   endgenerate

   // Reset state
   chk_reset_req: assert property (@(posedge pclk)
      $rose(presetn) |-> ext_request == 7'h00)
      else $error("request lines not idle after reset");
   chk_reset_ibe: assert property (@(posedge pclk)
      $rose(presetn) |-> st_r.ibe == `IRQPS_IBE_RESET)
      else $error("buffer enables not off after reset");

   // Register writes and reads
   chk_sel_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_en && paddr == `IRQPS_SEL_OFFSET && pstrb[0]) |=> $stable(st_r.sel))
      else $error("select changed without a write");
   chk_sel_read: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_en && paddr == `IRQPS_SEL_OFFSET) |=> prdata == {24'h000000, $past(st_r.sel)})
      else $error("select read data wrong");
   chk_rsvd_read: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_en && paddr == `IRQPS_SEL_OFFSET) |=> !prdata[`IRQPS_SEL_RSVD_BIT])
      else $error("reserved bit read as one");
   chk_ibe_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `IRQPS_IBE_OFFSET && pstrb[0] && pstrb[1])
      |=> st_r.ibe == $past(pwdata[10:0]))
      else $error("buffer enable write lost");
   chk_ibe_low_strb: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `IRQPS_IBE_OFFSET && pstrb[0] && !pstrb[1])
      |=> st_r.ibe == {$past(st_r.ibe[10:8]), $past(pwdata[7:0])})
      else $error("buffer enable strobe ignored");
   chk_ibe_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_en && paddr == `IRQPS_IBE_OFFSET && (pstrb[0] || pstrb[1])) |=> $stable(st_r.ibe))
      else $error("buffer enables changed without a write");
   chk_stat_read: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_en && paddr == `IRQPS_STAT_OFFSET) |=> prdata == {25'h0, $past(ext_request)})
      else $error("status read data wrong");

   // Pin buffers
   chk_buf_pass: assert property (@(posedge pclk) disable iff (!presetn)
      {port6_buffered, port2_buffered} == ({port6_line, port2_line} & st_r.ibe))
      else $error("buffered levels wrong");
   chk_buf_gate: assert property (@(posedge pclk) disable iff (!presetn)
      ({port6_buffered, port2_buffered} & ~st_r.ibe) == 11'h000)
      else $error("disabled buffer passes level");

   // Reselect with buffers on shows the new pin one clock later
   chk_sel_edge: assert property (@(posedge pclk) disable iff (!presetn)
      ($changed(st_r.sel[0]) && $stable(st_r.ibe) && st_r.ibe[0] && st_r.ibe[4]
      && $stable(port2_line[0]) && $stable(port6_line[0])
      && (port2_line[0] != port6_line[0])) |=> $changed(ext_request[0]))
      else $error("reselect edge missing");
endmodule
